/* src/ssmc_defs.svh */
// constants for the supply supervisor mask and settling control
// assumes a 250 MHz system clock; times are in ns
`ifndef SSMC_DEFS_SVH
`define SSMC_DEFS_SVH

`define SSMC_CLK_MHZ       250
`define SSMC_MASK_FAST_NS  2000
`define SSMC_MASK_SLOW_NS  150000
// least times: round up to whole cycles
`define SSMC_MASK_FAST_CYC ((`SSMC_MASK_FAST_NS * `SSMC_CLK_MHZ + 999) / 1000)
`define SSMC_MASK_SLOW_CYC ((`SSMC_MASK_SLOW_NS * `SSMC_CLK_MHZ + 999) / 1000)
`define SSMC_CNT_W         16
`define SSMC_SIDE_LOW      0
`define SSMC_SIDE_HIGH     1

`endif

/* src/ssmc_pkg.sv */
// types for the supply supervisor mask and settling control
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none

package ssmc_pkg;

	// power mode reported by the clock and power controller
	typedef enum logic [1:0] {
		SSMC_ACTIVE       = 2'h0,
		SSMC_DEEP_SLEEP_1 = 2'h1,
		SSMC_DEEP_SLEEP_2 = 2'h2,
		SSMC_DEEP_SLEEP_3 = 2'h3
	} ssmc_sleep_t;

	// wake-up hold-off sequencer
	typedef enum logic [1:0] {
		SSMC_ST_RUN,
		SSMC_ST_SLEEP,
		SSMC_ST_HOLD
	} ssmc_state_t;

endpackage : ssmc_pkg

`default_nettype wire

/* src/ssmc_top.sv */
// supervisor event masking, sleep shutdown and wake-up execution hold-off
// assumes control bits from software, comparator trips from the analog side
// Notes on behaviour
// - A re-enabled supervisor comparator has its events masked for 2 us in full-performance mode.
// - A supervisor trip sets its event flag and, with reset enabled, requests a power-on reset.
// - While an event flag is set the general-purpose outputs float as long as the comparator is settling or tripped.
// - With sleep retention clear, comparators turn off in deep sleep and on again when active.
// - With sleep retention set, comparators keep running through deep sleep.
// - After power-up-clear or reset the supervisors are forced on and their settling mask starts.
// - After power-up-clear, a software write to a supervisor control re-arms its event flag.
// - With the low side in normal mode, execution is held 150 us after the two deepest sleeps.
// - With each low-side unit (supervisor and monitor) off or fast, that hold-off lasts only 2 us.
// - The sub-main clock is not gated by the wake-up hold when it runs from the oscillator.
// - The low-side settling delay is 150 us in normal mode and 2 us in full-performance mode.
`default_nettype none
`include "ssmc_defs.svh"

module ssmc_top #(
	parameter int unsigned MASK_FAST_CYC = `SSMC_MASK_FAST_CYC,
	parameter int unsigned MASK_SLOW_CYC = `SSMC_MASK_SLOW_CYC,
	parameter int unsigned WAKE_SLOW_CYC = `SSMC_MASK_SLOW_CYC
) (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       power_up_clear_i,
	input  wire logic [1:0] sleep_level_i,
	input  wire logic [1:0] supervisor_on_i,
	input  wire logic [1:0] supervisor_full_performance_i,
	input  wire logic [1:0] supervisor_sleep_retain_i,
	input  wire logic [1:0] supervisor_reset_enable_i,
	input  wire logic [1:0] supervisor_ctl_write_i,
	input  wire logic [1:0] supervisor_flag_clear_i,
	input  wire logic [1:0] comparator_trip_i,
	input  wire logic       low_side_monitor_on_i,
	input  wire logic       low_side_monitor_fast_i,
	input  wire logic       sub_main_clock_from_osc_i,
	output logic      [1:0] supervisor_event_flag_o,
	output logic      [1:0] comparator_enable_o,
	output logic      [1:0] settling_o,
	output logic            por_request_o,
	output logic            gpio_hiz_o,
	output logic            cpu_hold_o,
	output logic            main_clock_gate_o,
	output logic            sub_main_clock_gate_o
);

	localparam int FAST_C = MASK_FAST_CYC;
	// the settling mask counts its full length so it never ends early; the wake
	// hold runs down to zero inclusive and therefore loads one less
	localparam logic [`SSMC_CNT_W-1:0] MASK_FAST_LEN = `SSMC_CNT_W'(MASK_FAST_CYC);
	localparam logic [`SSMC_CNT_W-1:0] MASK_FAST = `SSMC_CNT_W'(MASK_FAST_CYC - 1);
	localparam logic [`SSMC_CNT_W-1:0] MASK_SLOW = `SSMC_CNT_W'(MASK_SLOW_CYC);
	localparam logic [`SSMC_CNT_W-1:0] WAKE_SLOW = `SSMC_CNT_W'(WAKE_SLOW_CYC - 1);

	logic       deep_sleep;
	logic [1:0] trip_s;
	logic [1:0] set_ev;
	logic [1:0] next_flag;
	logic [1:0] next_en;

	// any sleep level counts as deep sleep for comparator shutdown
	assign deep_sleep = (ssmc_pkg::ssmc_sleep_t'(sleep_level_i) != ssmc_pkg::SSMC_ACTIVE);

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_side
			logic [2:0]              sync;
			logic                    next_trip;
			logic                    forced;
			logic                    next_forced;
			logic                    armed;
			logic                    next_armed;
			logic [`SSMC_CNT_W-1:0]  mask_cnt;
			logic [`SSMC_CNT_W-1:0]  next_mask_cnt;

			// comparator output is asynchronous; third stage filters a one-cycle glitch
			always_ff @(posedge clk_i) begin
				if (!rst_n_i) begin
					sync      <= 3'h0;
					trip_s[g] <= 1'b0;
				end else begin
					sync      <= {sync[1:0], comparator_trip_i[g]};
					trip_s[g] <= next_trip;
				end
			end

			always_comb begin
				next_trip = (sync[1] == sync[2]) ? sync[2] : trip_s[g];
				// forced on until software writes its own setting
				next_forced = power_up_clear_i | (forced & ~supervisor_ctl_write_i[g]);
				// power-up-clear on a disabled supervisor leaves the flag unarmed
				next_armed = armed;
				if (power_up_clear_i && !supervisor_on_i[g]) begin
					next_armed = 1'b0;
				end
				if (supervisor_ctl_write_i[g]) begin
					next_armed = 1'b1;
				end
				next_en[g] = (supervisor_on_i[g] | next_forced)
					& ~(deep_sleep & ~supervisor_sleep_retain_i[g]);
				next_mask_cnt = (mask_cnt != '0) ? mask_cnt - `SSMC_CNT_W'(1) : mask_cnt;
				// mask restarts on every re-enable and on power-up-clear
				if ((next_en[g] && !comparator_enable_o[g]) || power_up_clear_i) begin
					next_mask_cnt = supervisor_full_performance_i[g]
						? MASK_FAST_LEN : MASK_SLOW;
				end
				if (!next_en[g]) begin
					next_mask_cnt = '0;
				end
				set_ev[g] = trip_s[g] & comparator_enable_o[g] & armed
					& ~settling_o[g];
				// a trip in the clearing cycle wins over the clear
				next_flag[g] = set_ev[g]
					| (supervisor_event_flag_o[g] & ~supervisor_flag_clear_i[g]);
			end

			always_ff @(posedge clk_i) begin
				if (!rst_n_i) begin
					forced                     <= 1'b1;
					armed                      <= 1'b1;
					mask_cnt                   <= '0;
					comparator_enable_o[g]     <= 1'b0;
					settling_o[g]              <= 1'b0;
					supervisor_event_flag_o[g] <= 1'b0;
				end else begin
					forced                     <= next_forced;
					armed                      <= next_armed;
					mask_cnt                   <= next_mask_cnt;
					comparator_enable_o[g]     <= next_en[g];
					settling_o[g]              <= (next_mask_cnt != '0);
					supervisor_event_flag_o[g] <= next_flag[g];
				end
			end

			a_mask_on_enable: assert property (@(posedge clk_i) disable iff (!rst_n_i)
				$rose(comparator_enable_o[g]) |-> settling_o[g])
				else $error("comparator re-enabled without settling mask");
			a_no_flag_masked: assert property (@(posedge clk_i) disable iff (!rst_n_i)
				(settling_o[g] && !supervisor_event_flag_o[g]) |=> !supervisor_event_flag_o[g])
				else $error("event flag set during settling mask");
			a_flag_set_wins: assert property (@(posedge clk_i) disable iff (!rst_n_i)
				(set_ev[g] && supervisor_flag_clear_i[g]) |=> supervisor_event_flag_o[g])
				else $error("event lost against flag clear");
			a_sleep_shutdown: assert property (@(posedge clk_i) disable iff (!rst_n_i)
				(deep_sleep && !supervisor_sleep_retain_i[g]) |=> !comparator_enable_o[g])
				else $error("comparator left on in deep sleep");
			a_sleep_retain: assert property (@(posedge clk_i) disable iff (!rst_n_i)
				(supervisor_on_i[g] && supervisor_sleep_retain_i[g]) |=> comparator_enable_o[g])
				else $error("retained comparator switched off");
			a_clear_forces_on: assert property (@(posedge clk_i) disable iff (!rst_n_i)
				(power_up_clear_i && !deep_sleep) |=> comparator_enable_o[g] && settling_o[g])
				else $error("supervisor not forced on after power-up-clear");
			a_write_rearms: assert property (@(posedge clk_i) disable iff (!rst_n_i)
				supervisor_ctl_write_i[g] ##1 (trip_s[g] && comparator_enable_o[g]
					&& !settling_o[g]) |=> supervisor_event_flag_o[g])
				else $error("flag not re-armed by control write");
		end
	endgenerate

	// wake-up hold-off sequencer
	ssmc_pkg::ssmc_state_t  state;
	ssmc_pkg::ssmc_state_t  next_state;
	logic [`SSMC_CNT_W-1:0] hold_cnt;
	logic [`SSMC_CNT_W-1:0] next_hold_cnt;
	logic                   hold_slow;
	logic                   next_hold;

	// either low-side unit left in normal mode keeps the long hold
	assign hold_slow = (supervisor_on_i[`SSMC_SIDE_LOW]
		& ~supervisor_full_performance_i[`SSMC_SIDE_LOW])
		| (low_side_monitor_on_i & ~low_side_monitor_fast_i);

	always_comb begin
		next_state    = state;
		next_hold_cnt = hold_cnt;
		unique case (state)
			ssmc_pkg::SSMC_ST_RUN: begin
				if (sleep_level_i[1]) begin
					next_state = ssmc_pkg::SSMC_ST_SLEEP;
				end
			end
			ssmc_pkg::SSMC_ST_SLEEP: begin
				if (!deep_sleep) begin
					next_state    = ssmc_pkg::SSMC_ST_HOLD;
					next_hold_cnt = hold_slow ? WAKE_SLOW : MASK_FAST;
				end
			end
			ssmc_pkg::SSMC_ST_HOLD: begin
				if (hold_cnt == '0) begin
					next_state = ssmc_pkg::SSMC_ST_RUN;
				end else begin
					next_hold_cnt = hold_cnt - `SSMC_CNT_W'(1);
				end
			end
		endcase
		next_hold = (next_state == ssmc_pkg::SSMC_ST_HOLD);
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state                 <= ssmc_pkg::SSMC_ST_RUN;
			hold_cnt              <= '0;
			cpu_hold_o            <= 1'b0;
			main_clock_gate_o     <= 1'b0;
			sub_main_clock_gate_o <= 1'b0;
			por_request_o         <= 1'b0;
			gpio_hiz_o            <= 1'b0;
		end else begin
			state                 <= next_state;
			hold_cnt              <= next_hold_cnt;
			cpu_hold_o            <= next_hold;
			main_clock_gate_o     <= next_hold;
			// oscillator-fed sub-main clock runs through the hold
			sub_main_clock_gate_o <= next_hold & ~sub_main_clock_from_osc_i;
			por_request_o         <= |(set_ev & supervisor_reset_enable_i);
			gpio_hiz_o            <= |(supervisor_event_flag_o & (settling_o | trip_s));
		end
	end

	a_por_on_trip: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		|(set_ev & supervisor_reset_enable_i) |=> por_request_o)
		else $error("trip with reset enabled gave no reset request");
	a_gpio_float: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		|(supervisor_event_flag_o & trip_s) |=> gpio_hiz_o)
		else $error("outputs driven while flag set and comparator tripped");
	a_hold_fast_len: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		($rose(cpu_hold_o) && hold_cnt == MASK_FAST) |-> ##[1:FAST_C] !cpu_hold_o)
		else $error("fast wake hold too long");
	a_hold_slow_min: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		($rose(cpu_hold_o) && hold_cnt == WAKE_SLOW) |-> cpu_hold_o[*8])
		else $error("slow wake hold ended early");
	a_sub_clock_free: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		sub_main_clock_from_osc_i |=> !sub_main_clock_gate_o)
		else $error("oscillator sub-main clock gated by wake hold");

endmodule : ssmc_top

`default_nettype wire

/* dv/ssmc_top_tb.sv */
// self-checking bench for ssmc_top: masking, trips, sleep shutdown, wake hold-off
// assumes shortened mask counts; inputs change on the falling edge only
`default_nettype none

module ssmc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int FAST = 20;
	localparam int SLOW = 40;
	logic       clk_i = 1'b0, rst_n_i = 1'b0, power_up_clear_i = 1'b0;
	logic [1:0] sleep_level_i = 2'h0, supervisor_on_i = 2'h0, supervisor_full_performance_i = 2'h0;
	logic [1:0] supervisor_sleep_retain_i = 2'h0, supervisor_reset_enable_i = 2'h0;
	logic [1:0] supervisor_ctl_write_i = 2'h0, supervisor_flag_clear_i = 2'h0;
	logic [1:0] comparator_trip_i = 2'h0;
	logic       low_side_monitor_on_i = 1'b0, low_side_monitor_fast_i = 1'b0;
	logic       sub_main_clock_from_osc_i = 1'b0;
	logic [1:0] flag, cmp_en, settling;
	logic       por, hiz, hold, mgate, sgate, h1;
	int         err_total = 0, checks_done = 0, cyc = 0, n, lvl, exp_n;

	ssmc_top #(.MASK_FAST_CYC(FAST), .MASK_SLOW_CYC(SLOW), .WAKE_SLOW_CYC(SLOW)) dut (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .power_up_clear_i(power_up_clear_i),
		.sleep_level_i(sleep_level_i), .supervisor_on_i(supervisor_on_i),
		.supervisor_full_performance_i(supervisor_full_performance_i),
		.supervisor_sleep_retain_i(supervisor_sleep_retain_i),
		.supervisor_reset_enable_i(supervisor_reset_enable_i),
		.supervisor_ctl_write_i(supervisor_ctl_write_i),
		.supervisor_flag_clear_i(supervisor_flag_clear_i), .comparator_trip_i(comparator_trip_i),
		.low_side_monitor_on_i(low_side_monitor_on_i),
		.low_side_monitor_fast_i(low_side_monitor_fast_i),
		.sub_main_clock_from_osc_i(sub_main_clock_from_osc_i),
		.supervisor_event_flag_o(flag), .comparator_enable_o(cmp_en), .settling_o(settling),
		.por_request_o(por), .gpio_hiz_o(hiz), .cpu_hold_o(hold),
		.main_clock_gate_o(mgate), .sub_main_clock_gate_o(sgate)
	);

	always #2 clk_i = ~clk_i;

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : report_and_stop

	// hang guard: the whole sequence needs well under 3000 cycles
	always @(posedge clk_i) begin
		cyc++;
		if (cyc >= 6000) begin
			err_total++;
			report_and_stop();
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, got);
		end
	endtask : chk

	// counts falling edges within a window at which the picked output is high
	task automatic count_high(input int sel, input int win, output int cnt);
		logic v;
		cnt = 0;
		repeat (win) begin
			@(negedge clk_i);
			v = (sel == 0) ? settling[0] : ((sel == 1) ? settling[1] : hold);
			if (v === 1'b1) cnt++;
		end
	endtask : count_high

	task automatic pulse_write(input logic [1:0] sides);
		supervisor_ctl_write_i = sides;
		@(negedge clk_i);
		supervisor_ctl_write_i = 2'h0;
	endtask : pulse_write

	// hold-off is short only when low supervisor and monitor are each off or fast
	function automatic int exp_hold(int l, logic s_on, logic s_fp, logic m_on, logic m_fp);
		if (l < 2) return 0;
		return ((!s_on || s_fp) && (!m_on || m_fp)) ? FAST : SLOW;
	endfunction : exp_hold

	initial begin
		n = $urandom(81389);
		repeat (3) @(negedge clk_i);
		chk("outputs in reset", 32'h0, {flag, cmp_en, settling, por, hiz, hold, mgate, sgate});
		rst_n_i = 1'b1;
		count_high(0, 60, n);
		chk("reset settle len", SLOW, n);
		supervisor_on_i = 2'h3;
		pulse_write(2'h3);
		supervisor_on_i = 2'h2;
		repeat (2) @(negedge clk_i);
		chk("low side off", 2'h2, cmp_en);
		supervisor_on_i = 2'h3;
		supervisor_full_performance_i = 2'h1;
		comparator_trip_i = 2'h1;
		repeat (10) @(negedge clk_i);
		comparator_trip_i = 2'h0;
		count_high(0, 50, n);
		chk("trip while masked", 2'h0, flag);
		supervisor_on_i = 2'h2;
		@(negedge clk_i);
		supervisor_on_i = 2'h3;
		count_high(0, 60, n);
		chk("fast settle len", FAST, n);
		supervisor_reset_enable_i = 2'h1;
		comparator_trip_i = 2'h1;
		repeat (7) @(negedge clk_i);
		chk("trip flag por hiz", 3'h7, {flag[0], por, hiz});
		comparator_trip_i = 2'h0;
		repeat (6) @(negedge clk_i);
		chk("after trip gone", 3'h4, {flag[0], por, hiz});
		supervisor_flag_clear_i = 2'h1;
		@(negedge clk_i);
		supervisor_flag_clear_i = 2'h0;
		@(negedge clk_i);
		chk("flag cleared", 2'h0, flag);
		supervisor_reset_enable_i = 2'h0;
		low_side_monitor_on_i = 1'b1;
		for (int i = 0; i < 10; i++) begin
			lvl = (i == 0) ? 3 : $urandom_range(1, 3);
			supervisor_on_i = {1'b1, 1'(i != 0 && $urandom_range(0, 3) != 0)};
			supervisor_full_performance_i = 2'($urandom_range(0, 3));
			supervisor_sleep_retain_i = 2'($urandom_range(0, 3));
			low_side_monitor_on_i = 1'($urandom_range(0, 1));
			low_side_monitor_fast_i = 1'($urandom_range(0, 1));
			sub_main_clock_from_osc_i = 1'($urandom_range(0, 1));
			repeat (60) @(negedge clk_i);
			sleep_level_i = 2'(lvl);
			repeat (3) @(negedge clk_i);
			chk("sleep enables", supervisor_on_i & supervisor_sleep_retain_i, cmp_en);
			exp_n = exp_hold(lvl, supervisor_on_i[0], supervisor_full_performance_i[0],
				low_side_monitor_on_i, low_side_monitor_fast_i);
			sleep_level_i = 2'h0;
			@(negedge clk_i);
			h1 = hold;
			chk("wake gates", {1'(exp_n > 0), 1'(exp_n > 0 && !sub_main_clock_from_osc_i)},
				{mgate, sgate});
			count_high(2, 60, n);
			chk("hold len", exp_n, n + int'(h1));
			chk("awake enables", supervisor_on_i, cmp_en);
		end
		supervisor_on_i = 2'h2;
		supervisor_full_performance_i = 2'h0;
		repeat (3) @(negedge clk_i);
		power_up_clear_i = 1'b1;
		@(negedge clk_i);
		power_up_clear_i = 1'b0;
		count_high(0, 60, n);
		chk("clear forced on", 2'h3, cmp_en);
		chk("clear settle len", SLOW - 1, n);
		comparator_trip_i = 2'h1;
		repeat (8) @(negedge clk_i);
		chk("disarmed trip", 2'h0, flag);
		supervisor_on_i = 2'h3;
		pulse_write(2'h1);
		repeat (60) @(negedge clk_i);
		chk("rearmed trip", 2'h1, flag);
		comparator_trip_i = 2'h0;
		report_and_stop();
	end
endmodule : ssmc_top_tb

`default_nettype wire
